/* logic/src_pkg.sv */
package src_pkg;
    // reset delay: 250 us at 250 MHz
    localparam int SRC_CLK_MHZ = 250;
    localparam int SRC_RST_DLY_US = 250;
    localparam int SRC_RST_DLY_CYC = SRC_RST_DLY_US * SRC_CLK_MHZ;
    localparam int SRC_CNT_W = 18;
    localparam int SRC_PIN_LOW_CYC = 16;

    // device register map (7-bit addresses)
    localparam logic [6:0] SRC_DAC0_ADDR = 7'h30;
    localparam logic [6:0] SRC_DAC_LAST_ADDR = 7'h3B;
    localparam logic [6:0] SRC_LATCH_ADDR = 7'h50;
    localparam logic [6:0] SRC_CLEAR_ADDR = 7'h51;
    localparam logic [6:0] SRC_PWR_ADDR = 7'h6B;
    localparam logic [6:0] SRC_SRST_ADDR = 7'h7C;
    localparam logic [15:0] SRC_SRST_KEY = 16'h6600;
    localparam logic [15:0] SRC_PWR_RST = 16'h0000;
    localparam logic [15:0] SRC_PWR_MASK = 16'h7FFE;
    localparam logic [15:0] SRC_PWR_DAC_MASK = 16'h1FFE;
    localparam logic [15:0] SRC_I2C_UNDEF = 16'h0000;
    localparam int SRC_PADC_BIT = 14;
    localparam int SRC_PREF_BIT = 13;
    localparam int SRC_PDAC0_BIT = 12;

    // host apb map
    localparam logic [7:0] SRC_CMD_OFS = 8'h00;
    localparam logic [7:0] SRC_STAT_OFS = 8'h04;
    localparam int SRC_CMD_WE_BIT = 24;
    localparam int SRC_CMD_I2C_BIT = 25;
    localparam int SRC_CMD_HWR_BIT = 26;
    localparam int SRC_ST_BUSY_BIT = 16;
    localparam int SRC_ST_RDY_BIT = 17;
    localparam int SRC_ST_REF_BIT = 18;
    localparam int SRC_ST_HWD_BIT = 19;
    localparam int SRC_ST_RES_BIT = 20;

    typedef enum logic [1:0] {SRC_HOLD, SRC_WAIT, SRC_READY} src_dst_t;

    typedef struct packed {
        src_dst_t st;
        logic [SRC_CNT_W-1:0] cnt;
        logic ack;
        logic [15:0] rdata;
        logic [15:0] pwr;
        logic [15:0] srst;
        logic [11:0][11:0] data;
        logic [11:0] latch;
        logic [11:0] clr;
        logic [11:0][11:0] code;
    } src_dev_t;

    localparam src_dev_t SRC_DEV_RST = '{st: SRC_WAIT, cnt: '0, ack: 1'b0,
        rdata: 16'h0000, pwr: SRC_PWR_RST, srst: 16'h0000, data: '0,
        latch: 12'h000, clr: 12'h000, code: '0};

    typedef enum logic [1:0] {SRCH_WAIT, SRCH_IDLE, SRCH_REQ, SRCH_PIN} src_hst_t;

    typedef struct packed {
        src_hst_t st;
        logic [SRC_CNT_W-1:0] cnt;
        logic pin_n;
        logic req;
        logic we;
        logic i2c;
        logic [6:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic refused;
        logic hw_done;
        logic [2:0] restore;
        logic [31:0] prdata;
    } src_host_t;

    localparam src_host_t SRC_HOST_RST = '{st: SRCH_WAIT, cnt: '0,
        pin_n: 1'b1, req: 1'b0, we: 1'b0, i2c: 1'b0, addr: 7'h00,
        wdata: 16'h0000, rdata: 16'h0000, refused: 1'b0, hw_done: 1'b0,
        restore: 3'b111, prdata: 32'h0000_0000};
endpackage

/* logic/src_link_if.sv */
`timescale 1ns/1ps
interface src_link_if;
    logic req;
    logic we;
    logic i2c;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic rst_pin_n;

    modport dev (
        input req,
        input we,
        input i2c,
        input addr,
        input wdata,
        input rst_pin_n,
        output ack,
        output rdata
    );

    modport host (
        output req,
        output we,
        output i2c,
        output addr,
        output wdata,
        output rst_pin_n,
        input ack,
        input rdata
    );
endinterface

/* logic/src_dev.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// RQ1: soft reset keeps DAC data, latch, clear
// RQ2: hardware reset clears everything including DAC
// RQ3: SPI soft reset only on 6600h at 7Ch
// RQ4: I2C soft reset on any byte
// RQ5: I2C read of 7Ch undefined, host discards
// RQ6: I2C soft reset register is one byte
// RQ7: I2C write: address, 7Ch, byte, all acknowledged
// RQ8: host rewrites DAC registers before DAC power-on
// RQ9: power-on defaults, wait 250 us
// RQ10: reset pin rise, wait 250 us
// RQ11: analog blocks off after reset
// RQ12: host pulses hardware reset before power-down write
// RQ13: power-down bit 1 enables block, resets 0
// RQ14: ignore transactions during any reset delay
module src_dev #(
    parameter int RST_DLY_CYC = src_pkg::SRC_RST_DLY_CYC
) (
    // clock and power-on reset
    input wire logic clk_in,
    input wire logic rst_in,
    // serial link
    src_link_if.dev link,
    // analog controls and link ready flag
    output logic adc_on_out,
    output logic ref_on_out,
    output logic [11:0] dac_on_out,
    output logic [11:0][11:0] dac_code_out,
    output logic link_ready_out
);
    import src_pkg::*;

    src_dev_t q;
    src_dev_t d;

    ////////////////////////////////////////////////////////////////////////

    // soft reset: all defaults, DAC state carried over
    function automatic src_dev_t soft_rst(input src_dev_t s);
        src_dev_t r;
        r = SRC_DEV_RST;
        r.data = s.data; // RQ1
        r.latch = s.latch; // RQ1
        r.clr = s.clr; // RQ1
        r.code = s.code; // RQ1
        return r;
    endfunction

    // dac data window decode, shared by the write and read paths
    function automatic logic is_dac(input logic [6:0] a);
        return a >= SRC_DAC0_ADDR && a <= SRC_DAC_LAST_ADDR;
    endfunction

    function automatic logic [3:0] dac_idx(input logic [6:0] a);
        return 4'(a - SRC_DAC0_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        d = q;
        d.ack = 1'b0;
        unique case (q.st)
            SRC_HOLD:
            begin
                d.st = SRC_WAIT; // RQ10
                d.cnt = '0;
            end
            SRC_WAIT:
            begin
                // requests are not looked at while counting
                if (q.cnt == SRC_CNT_W'(RST_DLY_CYC - 1)) // RQ9 RQ10 RQ14
                begin
                    d.st = SRC_READY;
                end
                else
                begin
                    d.cnt = q.cnt + SRC_CNT_W'(1);
                end
            end
            SRC_READY:
            begin
                // ack high blocks a second take of the same request
                if (link.req && !q.ack)
                begin
                    d.ack = 1'b1; // RQ7
                    if (link.we)
                    begin
                        if (link.addr == SRC_SRST_ADDR)
                        begin
                            if (link.i2c ||
                                link.wdata == SRC_SRST_KEY) // RQ3 RQ4
                            begin
                                d = soft_rst(q); // RQ1 RQ11
                                d.ack = 1'b1;
                            end
                            else
                            begin
                                d.srst = link.wdata;
                            end
                        end
                        else if (link.addr == SRC_PWR_ADDR)
                        begin
                            d.pwr = link.wdata & SRC_PWR_MASK; // RQ13
                        end
                        else if (link.addr == SRC_LATCH_ADDR)
                        begin
                            d.latch = link.wdata[11:0];
                        end
                        else if (link.addr == SRC_CLEAR_ADDR)
                        begin
                            d.clr = link.wdata[11:0];
                        end
                        else if (is_dac(link.addr))
                        begin
                            d.data[dac_idx(link.addr)] = link.wdata[11:0];
                        end
                    end
                    else
                    begin
                        if (link.addr == SRC_SRST_ADDR)
                        begin
                            // only one byte, of no meaning, in i2c mode
                            d.rdata = link.i2c ?
                                SRC_I2C_UNDEF : q.srst; // RQ5 RQ6
                        end
                        else if (link.addr == SRC_PWR_ADDR)
                        begin
                            d.rdata = q.pwr;
                        end
                        else if (link.addr == SRC_LATCH_ADDR)
                        begin
                            d.rdata = {4'h0, q.latch};
                        end
                        else if (link.addr == SRC_CLEAR_ADDR)
                        begin
                            d.rdata = {4'h0, q.clr};
                        end
                        else if (is_dac(link.addr))
                        begin
                            d.rdata = {4'h0, q.data[dac_idx(link.addr)]};
                        end
                        else
                        begin
                            d.rdata = 16'h0000;
                        end
                    end
                end
            end
        endcase
        // clear forces zero code; a latch bit makes the channel transparent
        for (int n = 0; n < 12; n++)
        begin
            if (q.clr[n])
            begin
                d.code[n] = 12'h000;
            end
            else if (q.latch[n])
            begin
                d.code[n] = q.data[n];
            end
        end
        // pin low holds every register at its default, except the state, which is held at SRC_HOLD
        if (!link.rst_pin_n)
        begin
            d = SRC_DEV_RST; // RQ2 RQ11
            d.st = SRC_HOLD;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q <= SRC_DEV_RST; // RQ9
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign link.ack = q.ack;
    assign link.rdata = q.rdata;
    assign adc_on_out = q.pwr[SRC_PADC_BIT]; // RQ13
    assign ref_on_out = q.pwr[SRC_PREF_BIT]; // RQ13
    assign dac_code_out = q.code;
    assign link_ready_out = (q.st == SRC_READY);

    genvar g;
    generate
        for (g = 0; g < 12; g++)
        begin : g_dac
            assign dac_on_out[g] = q.pwr[SRC_PDAC0_BIT - g]; // RQ13
        end
    endgenerate
endmodule

/* logic/src_host.sv */
`timescale 1ns/1ps
module src_host #(
    parameter int RST_DLY_CYC = src_pkg::SRC_RST_DLY_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // link to device
    src_link_if.host link
);
    import src_pkg::*;

    src_host_t q;
    src_host_t d;
    logic wr_cmd;
    logic wr_stat;
    logic pwr_bad;

    ////////////////////////////////////////////////////////////////////////

    assign wr_cmd = psel_in && penable_in && pwrite_in &&
                    paddr_in == SRC_CMD_OFS;
    assign wr_stat = psel_in && penable_in && pwrite_in &&
                     paddr_in == SRC_STAT_OFS;
    // power-down write refused before a pin reset, or turning a DAC on with DACs not restored
    assign pwr_bad = pwdata_in[SRC_CMD_WE_BIT] &&
        pwdata_in[22:16] == SRC_PWR_ADDR &&
        (!q.hw_done || // RQ12
         (q.restore != 3'b111 &&
          (pwdata_in[15:0] & SRC_PWR_DAC_MASK) != 16'h0000)); // RQ8

    always_comb
    begin
        d = q;
        if (wr_stat && pwdata_in[SRC_ST_REF_BIT])
        begin
            d.refused = 1'b0;
        end
        unique case (q.st)
            SRCH_WAIT:
            begin
                if (q.cnt == SRC_CNT_W'(RST_DLY_CYC - 1)) // RQ9 RQ10
                begin
                    d.st = SRCH_IDLE;
                end
                else
                begin
                    d.cnt = q.cnt + SRC_CNT_W'(1);
                end
            end
            SRCH_IDLE:
            begin
                if (wr_cmd && pwdata_in[SRC_CMD_HWR_BIT])
                begin
                    d.st = SRCH_PIN; // RQ12
                    d.cnt = '0;
                    d.pin_n = 1'b0;
                end
                else if (wr_cmd && pwr_bad)
                begin
                    d.refused = 1'b1;
                end
                else if (wr_cmd)
                begin
                    d.st = SRCH_REQ;
                    d.req = 1'b1;
                    d.we = pwdata_in[SRC_CMD_WE_BIT];
                    d.i2c = pwdata_in[SRC_CMD_I2C_BIT];
                    d.addr = pwdata_in[22:16];
                    // i2c carries one byte to the soft reset register
                    d.wdata = (pwdata_in[SRC_CMD_I2C_BIT] &&
                        pwdata_in[22:16] == SRC_SRST_ADDR) ?
                        {8'h00, pwdata_in[7:0]} : pwdata_in[15:0]; // RQ6
                end
            end
            SRCH_REQ:
            begin
                if (link.ack)
                begin
                    d.req = 1'b0;
                    d.st = SRCH_IDLE;
                    if (!q.we)
                    begin
                        d.rdata = (q.i2c && q.addr == SRC_SRST_ADDR) ?
                            SRC_I2C_UNDEF : link.rdata; // RQ5
                    end
                    else if (q.addr == SRC_SRST_ADDR &&
                             (q.i2c || q.wdata == SRC_SRST_KEY)) // RQ3 RQ4
                    begin
                        d.st = SRCH_WAIT; // RQ7
                        d.cnt = '0;
                        d.restore = 3'b000; // RQ8
                    end
                    else if (q.addr >= SRC_DAC0_ADDR &&
                             q.addr <= SRC_DAC_LAST_ADDR)
                    begin
                        d.restore[0] = 1'b1; // RQ8
                    end
                    else if (q.addr == SRC_LATCH_ADDR)
                    begin
                        d.restore[1] = 1'b1; // RQ8
                    end
                    else if (q.addr == SRC_CLEAR_ADDR)
                    begin
                        d.restore[2] = 1'b1; // RQ8
                    end
                end
            end
            SRCH_PIN:
            begin
                if (q.cnt == SRC_CNT_W'(SRC_PIN_LOW_CYC - 1))
                begin
                    d.pin_n = 1'b1;
                    d.st = SRCH_WAIT; // RQ10
                    d.cnt = '0;
                    d.hw_done = 1'b1;
                    d.restore = 3'b111;
                end
                else
                begin
                    d.cnt = q.cnt + SRC_CNT_W'(1);
                end
            end
        endcase
        // a command while busy is not lost silently; set wins over clear
        if (wr_cmd && q.st != SRCH_IDLE)
        begin
            d.refused = 1'b1;
        end
        if (psel_in && !penable_in)
        begin
            d.prdata = 32'h0000_0000;
            if (paddr_in == SRC_STAT_OFS)
            begin
                d.prdata[15:0] = q.rdata;
                d.prdata[SRC_ST_BUSY_BIT] = (q.st != SRCH_IDLE);
                d.prdata[SRC_ST_RDY_BIT] = (q.st == SRCH_IDLE);
                d.prdata[SRC_ST_REF_BIT] = q.refused;
                d.prdata[SRC_ST_HWD_BIT] = q.hw_done;
                d.prdata[SRC_ST_RES_BIT] = (q.restore != 3'b111);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q <= SRC_HOST_RST;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign prdata_out = q.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    assign link.req = q.req;
    assign link.we = q.we;
    assign link.i2c = q.i2c;
    assign link.addr = q.addr;
    assign link.wdata = q.wdata;
    assign link.rst_pin_n = q.pin_n;
endmodule

/* tb/src_link_sva.sv */
`timescale 1ns/1ps
module src_link_sva #(
    parameter int RST_DLY_CYC = src_pkg::SRC_RST_DLY_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // link signals
    input wire logic req,
    input wire logic we,
    input wire logic i2c,
    input wire logic [6:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic rst_pin_n
);
    import src_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // cycles since the last reset of any kind, and pin low length
    logic [SRC_CNT_W-1:0] quiet_q;
    logic [4:0] low_q;
    logic srst_ack;
    assign srst_ack = ack && we && addr == SRC_SRST_ADDR
        && (i2c || wdata == SRC_SRST_KEY);
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            quiet_q <= '0;
            low_q <= '0;
        end
        else
        begin
            if (!rst_pin_n || srst_ack)
                quiet_q <= '0;
            else if (quiet_q != '1)
                quiet_q <= quiet_q + 1'b1;
            low_q <= rst_pin_n ? 5'h00 : low_q + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_take;
        req && !ack;
    endsequence
    sequence s_answer;
        ack && req;
    endsequence
    AST_HANDSHAKE: assert property (s_take ##1 s_answer
        |=> !ack && !req)
        else $error("link handshake out of order");
    AST_ACK_CAUSE: assert property ($rose(ack) |-> $past(req))
        else $error("ack without request");
    AST_REQ_HOLD: assert property (s_take |=> req && $stable(addr)
        && $stable(we) && $stable(wdata) && $stable(i2c))
        else $error("request changed before ack");
    AST_QUIET: assert property (ack |-> quiet_q >= RST_DLY_CYC)
        else $error("ack inside reset delay");
    AST_READY_ANSWER: assert property (req && !ack
        && quiet_q >= RST_DLY_CYC + 4 |=> ack)
        else $error("no answer after reset delay");
    AST_PIN_LEN: assert property ($rose(rst_pin_n) |-> low_q == 5'h10)
        else $error("reset pin pulse length wrong");
    AST_PIN_SILENT: assert property (!rst_pin_n |=> !ack)
        else $error("ack while reset pin low");
    AST_I2C_UNDEF: assert property (ack && !we && i2c
        && addr == SRC_SRST_ADDR |-> rdata == SRC_I2C_UNDEF)
        else $error("byte mode reset register read value");
    AST_I2C_BYTE: assert property (req && we && i2c
        && addr == SRC_SRST_ADDR |-> wdata[15:8] == 8'h00)
        else $error("byte mode reset write wider than a byte");
endmodule

/* tb/soft_reset_and_startup_control_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("unexpected at %0t: got %h expected %h", \
                $time, got, exp); \
        end \
    end
module soft_reset_and_startup_control_test;
    import src_pkg::*;
    // short delay keeps the run small; both ends must agree on it
    localparam int DLY = 20;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adc_on;
    logic ref_on;
    logic [11:0] dac_on;
    logic [11:0][11:0] dac_code;
    logic link_ready;
    logic [31:0] s;
    logic [15:0] v;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    always #2 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    src_link_if src_link_if_inst ();
    src_dev #(.RST_DLY_CYC(DLY)) src_dev_inst (.clk_in(clk_in),
        .rst_in(rst_in), .link(src_link_if_inst.dev), .adc_on_out(adc_on),
        .ref_on_out(ref_on), .dac_on_out(dac_on), .dac_code_out(dac_code),
        .link_ready_out(link_ready));
    src_host #(.RST_DLY_CYC(DLY)) src_host_inst (.clk_in(clk_in),
        .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .link(src_link_if_inst.host));
    src_link_sva #(.RST_DLY_CYC(DLY)) src_link_sva_inst (.clk_in(clk_in),
        .rst_in(rst_in), .req(src_link_if_inst.req),
        .we(src_link_if_inst.we), .i2c(src_link_if_inst.i2c),
        .addr(src_link_if_inst.addr), .wdata(src_link_if_inst.wdata),
        .ack(src_link_if_inst.ack), .rdata(src_link_if_inst.rdata),
        .rst_pin_n(src_link_if_inst.rst_pin_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] cmd_word(input logic we, input logic i2c,
        input logic hw, input logic [6:0] a, input logic [15:0] d);
        logic [31:0] c;
        c = {9'h000, a, d};
        c[SRC_CMD_WE_BIT] = we;
        c[SRC_CMD_I2C_BIT] = i2c;
        c[SRC_CMD_HWR_BIT] = hw;
        return c;
    endfunction
    // polls status until the link is idle; a link stuck busy is a mismatch
    task automatic idle();
        int k;
        k = 0;
        do
        begin
            apb(1'b0, SRC_STAT_OFS, 32'h0000_0000, s);
            k++;
        end
        while (!(s[SRC_ST_BUSY_BIT] === 1'b0 && s[SRC_ST_RDY_BIT] === 1'b1)
            && k < 200);
        if (s[SRC_ST_BUSY_BIT] !== 1'b0)
        begin
            errors++;
            $display("unexpected at %0t: link stuck busy", $time);
        end
    endtask
    // refused orders end at once
    task automatic cmd(input logic we, input logic i2c, input logic hw,
        input logic [6:0] a, input logic [15:0] d);
        apb(1'b1, SRC_CMD_OFS, cmd_word(we, i2c, hw, a, d), s);
        idle();
    endtask
    task automatic rd(input logic i2c, input logic [6:0] a);
        cmd(1'b0, i2c, 1'b0, a, 16'h0000);
        v = s[15:0];
    endtask
    task automatic clear_refused();
        apb(1'b1, SRC_STAT_OFS, 32'h1 << SRC_ST_REF_BIT, s);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (link_ready !== 1'b1 && n < 1000);
        `CHK(n, DLY + 1)
        `CHK({adc_on, ref_on, dac_on}, 14'h0000)
        `CHK(dac_code, 144'h0)
        apb(1'b0, SRC_STAT_OFS, 32'h0000_0000, s);
        `CHK(s[SRC_ST_RDY_BIT], 1'b1)
        apb(1'b1, 8'h08, 32'hFFFF_FFFF, s);
        apb(1'b0, 8'h08, 32'h0000_0000, s);
        `CHK(s, 32'h0000_0000)
        `CHK(pslverr, 1'b0)
        cmd(1'b1, 1'b0, 1'b0, SRC_PWR_ADDR, 16'h6000);
        `CHK(s[SRC_ST_REF_BIT], 1'b1)
        `CHK(adc_on, 1'b0)
        clear_refused();
        cmd(1'b0, 1'b0, 1'b1, 7'h00, 16'h0000);
        `CHK(s[SRC_ST_HWD_BIT:SRC_ST_REF_BIT], 2'b10)
        cmd(1'b1, 1'b0, 1'b0, SRC_PWR_ADDR, 16'h6000);
        `CHK({adc_on, ref_on}, 2'b11)
        cmd(1'b1, 1'b0, 1'b0, SRC_DAC0_ADDR, 16'h0ABC);
        cmd(1'b1, 1'b0, 1'b0, SRC_LATCH_ADDR, 16'h0001);
        cmd(1'b1, 1'b0, 1'b0, SRC_PWR_ADDR, 16'h7000);
        `CHK(dac_on, 12'h001)
        `CHK(dac_code[0], 12'hABC)
        cmd(1'b1, 1'b0, 1'b0, SRC_SRST_ADDR, 16'h1234);
        rd(1'b0, SRC_SRST_ADDR);
        `CHK(v, 16'h1234)
        `CHK(adc_on, 1'b1)
        // second order lands while the first is in flight
        apb(1'b1, SRC_CMD_OFS,
            cmd_word(1'b1, 1'b0, 1'b0, SRC_SRST_ADDR, 16'h6600), s);
        apb(1'b1, SRC_CMD_OFS,
            cmd_word(1'b0, 1'b0, 1'b0, SRC_DAC0_ADDR, 16'h0000), s);
        idle();
        cmd(1'b0, 1'b0, 1'b0, SRC_PWR_ADDR, 16'h0000);
        `CHK(s[SRC_ST_RES_BIT], 1'b1)
        `CHK({adc_on, ref_on, dac_on}, 14'h0000)
        `CHK(dac_code[0], 12'hABC)
        `CHK(s[15:0], 16'h0000)
        `CHK(s[SRC_ST_REF_BIT], 1'b1)
        apb(1'b0, SRC_STAT_OFS, 32'h0000_0000, s);
        clear_refused();
        rd(1'b0, SRC_DAC0_ADDR);
        `CHK(v, 16'h0ABC)
        rd(1'b0, SRC_LATCH_ADDR);
        `CHK(v, 16'h0001)
        rd(1'b0, SRC_SRST_ADDR);
        `CHK(v, 16'h0000)
        cmd(1'b1, 1'b0, 1'b0, SRC_PWR_ADDR, 16'h7000);
        `CHK(s[SRC_ST_REF_BIT], 1'b1)
        `CHK(dac_on, 12'h000)
        clear_refused();
        cmd(1'b1, 1'b0, 1'b0, SRC_DAC0_ADDR, 16'h0ABC);
        cmd(1'b1, 1'b0, 1'b0, SRC_LATCH_ADDR, 16'h0001);
        cmd(1'b1, 1'b0, 1'b0, SRC_CLEAR_ADDR, 16'h0000);
        `CHK(s[SRC_ST_RES_BIT], 1'b0)
        cmd(1'b1, 1'b0, 1'b0, SRC_PWR_ADDR, 16'h7000);
        `CHK(dac_on, 12'h001)
        cmd(1'b1, 1'b1, 1'b0, SRC_SRST_ADDR, 16'h005A);
        `CHK({adc_on, dac_on}, 13'h0000)
        `CHK(dac_code[0], 12'hABC)
        rd(1'b1, SRC_SRST_ADDR);
        `CHK(v, 16'h0000)
        cmd(1'b0, 1'b0, 1'b1, 7'h00, 16'h0000);
        `CHK(dac_code[0], 12'h000)
        rd(1'b0, SRC_DAC0_ADDR);
        `CHK(v, 16'h0000)
        rd(1'b0, SRC_LATCH_ADDR);
        `CHK(v, 16'h0000)
        report_and_stop();
    end
endmodule
